//--- rtl/sram_burst_defines.svh
// Constants shared by the burst static RAM controller files
`ifndef SRAM_BURST_DEFINES_SVH
`define SRAM_BURST_DEFINES_SVH

// Burst counter width and its load value
`define BURST_CNT_W 2
`define BURST_CNT_START 2'h0
`define BURST_CNT_STEP 2'h1

// Default array geometry
`define DEF_ADDR_W 18
`define DEF_BYTE_LANES 4
`define DEF_BYTE_W 9

// Sleep request synchroniser reset level
`define SLEEP_SYNC_RESET 1'h0

`endif

//--- rtl/sram_burst_pkg.sv
// Types shared by the burst static RAM controller
package sram_burst_pkg;

   // Operation of the most recent burst begin, or deselected
   typedef enum logic [1:0] {
      OP_DESELECT,
      OP_READ,
      OP_WRITE
   } op_state_t;

endpackage : sram_burst_pkg

//--- rtl/burst_addr_gen.sv
// Two-bit burst address generator, linear or interleaved order
`include "sram_burst_defines.svh"

module burst_addr_gen (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic advance_i,
   input wire logic [`BURST_CNT_W-1:0] start_i,
   input wire logic interleave_i,
   output logic [`BURST_CNT_W-1:0] cur_low_o,
   output logic [`BURST_CNT_W-1:0] next_low_o,
   output logic [`BURST_CNT_W-1:0] count_o
);

   logic [`BURST_CNT_W-1:0] start;
   logic [`BURST_CNT_W-1:0] count;

   function automatic logic [`BURST_CNT_W-1:0] form_low(
      input logic [`BURST_CNT_W-1:0] base,
      input logic [`BURST_CNT_W-1:0] step,
      input logic interleaved
   );
      if (interleaved) begin
         form_low = base ^ step;
      end else begin
         form_low = base + step;
      end
   endfunction : form_low

   // Count wraps modulo four, so the fifth access reuses the start
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         start <= `BURST_CNT_START;
         count <= `BURST_CNT_START;
      end else if (load_i) begin
         start <= start_i;
         count <= `BURST_CNT_START;
      end else if (advance_i) begin
         count <= count + `BURST_CNT_STEP;
      end
   end

   assign cur_low_o = form_low(start, count, interleave_i);
   assign next_low_o = form_low(start, count + `BURST_CNT_STEP, interleave_i);
   assign count_o = count;

endmodule : burst_addr_gen

//--- rtl/sram_array.sv
// Byte-writable storage array with registered read data
`include "sram_burst_defines.svh"

module sram_array #(
   parameter int ADDR_W = `DEF_ADDR_W,
   parameter int BYTE_LANES = `DEF_BYTE_LANES,
   parameter int BYTE_W = `DEF_BYTE_W
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic rd_en_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   input wire logic [BYTE_LANES-1:0] wr_lane_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [BYTE_LANES*BYTE_W-1:0] wr_data_i,
   output logic [BYTE_LANES*BYTE_W-1:0] rd_data_o
);

   // Each lane keeps its own storage, so every array has one writer
   for (genvar g = 0; g < BYTE_LANES; g++) begin : g_lane
      logic [BYTE_W-1:0] mem [0:(1<<ADDR_W)-1];

      always_ff @(posedge clk_i) begin
         if (wr_lane_i[g]) begin
            mem[wr_addr_i] <= wr_data_i[g*BYTE_W +: BYTE_W];
         end
      end

      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            rd_data_o[g*BYTE_W +: BYTE_W] <= '0;
         end else if (rd_en_i) begin
            rd_data_o[g*BYTE_W +: BYTE_W] <= mem[rd_addr_i];
         end
      end
   end

endmodule : sram_array

//--- rtl/sync_sram_burst_control.sv
// Synchronous no-turnaround static RAM: command decode, burst and data timing
`include "sram_burst_defines.svh"

module sync_sram_burst_control
   import sram_burst_pkg::*;
#(
   parameter int ADDR_W = `DEF_ADDR_W,
   parameter int BYTE_LANES = `DEF_BYTE_LANES,
   parameter int BYTE_W = `DEF_BYTE_W
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic clock_enable_n_i,
   input wire logic advance_load_i,
   input wire logic write_n_i,
   input wire logic [BYTE_LANES-1:0] byte_lane_write_n_i,
   input wire logic chip_select_1_n_i,
   input wire logic chip_select_2_i,
   input wire logic chip_select_3_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i,
   input wire logic burst_order_sel_n_i,
   input wire logic flow_through_sel_n_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [BYTE_LANES*BYTE_W-1:0] dq_i,
   output logic [BYTE_LANES*BYTE_W-1:0] dq_o,
   output logic [BYTE_LANES*BYTE_W-1:0] dq_oe_o
);

   localparam int DATA_W = BYTE_LANES * BYTE_W;

   if (ADDR_W <= `BURST_CNT_W || BYTE_LANES < 1 || BYTE_W < 1) begin : g_check
      $error("sync_sram_burst_control: unsupported geometry");
   end

   // Sleep request is asynchronous: two flops before use
   logic sleep_meta;
   logic sleep_req;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sleep_meta <= `SLEEP_SYNC_RESET;
         sleep_req <= `SLEEP_SYNC_RESET;
      end else begin
         sleep_meta <= sleep_request_i;
         sleep_req <= sleep_meta;
      end
   end

   // Command decode
   logic active;
   logic load_cmd;
   logic deselect_cmd;
   logic any_lane;
   logic pipe_mode;
   op_state_t state;
   op_state_t next_state;
   logic do_read;
   logic do_write;

   assign active = !clock_enable_n_i && !sleep_req;
   assign load_cmd = !advance_load_i;
   assign deselect_cmd = chip_select_1_n_i || chip_select_3_n_i || !chip_select_2_i;
   assign any_lane = !(&byte_lane_write_n_i);
   assign pipe_mode = flow_through_sel_n_i;

   always_comb begin
      if (load_cmd && deselect_cmd) begin
         next_state = OP_DESELECT;
      end else if (load_cmd && write_n_i) begin
         next_state = OP_READ;
      end else if (load_cmd) begin
         next_state = OP_WRITE;
      end else begin
         next_state = state;
      end
   end

   assign do_read = active && next_state == OP_READ;
   assign do_write = active && next_state == OP_WRITE && any_lane;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= OP_DESELECT;
      end else if (active) begin
         state <= next_state;
      end
   end

   // Burst address generation
   logic burst_load;
   logic burst_advance;
   logic [ADDR_W-1:`BURST_CNT_W] addr_hi;
   logic [`BURST_CNT_W-1:0] cur_low;
   logic [`BURST_CNT_W-1:0] next_low;
   logic [`BURST_CNT_W-1:0] burst_count;
   logic [ADDR_W-1:0] access_addr;

   assign burst_load = active && load_cmd && !deselect_cmd;
   assign burst_advance = active && !load_cmd && state != OP_DESELECT;

   burst_addr_gen u_burst (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .load_i(burst_load),
      .advance_i(burst_advance),
      .start_i(addr_i[`BURST_CNT_W-1:0]),
      .interleave_i(burst_order_sel_n_i),
      .cur_low_o(cur_low),
      .next_low_o(next_low),
      .count_o(burst_count)
   );

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         addr_hi <= '0;
      end else if (burst_load) begin
         addr_hi <= addr_i[ADDR_W-1:`BURST_CNT_W];
      end
   end

   // Load uses the pins, continue uses the counter's next address
   assign access_addr = load_cmd ? addr_i
                      : {addr_hi, next_low};

   // Late write pipeline: stage one after capture, stage two for pipeline mode
   logic wr1_valid;
   logic wr2_valid;
   logic [ADDR_W-1:0] wr1_addr;
   logic [ADDR_W-1:0] wr2_addr;
   logic [BYTE_LANES-1:0] wr1_lane;
   logic [BYTE_LANES-1:0] wr2_lane;
   logic [BYTE_LANES-1:0] commit_lane;
   logic [ADDR_W-1:0] commit_addr;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr1_valid <= 1'h0;
         wr2_valid <= 1'h0;
         wr1_addr <= '0;
         wr2_addr <= '0;
         wr1_lane <= '0;
         wr2_lane <= '0;
      end else if (active) begin
         wr1_valid <= do_write;
         wr1_addr <= access_addr;
         wr1_lane <= ~byte_lane_write_n_i;
         wr2_valid <= wr1_valid;
         wr2_addr <= wr1_addr;
         wr2_lane <= wr1_lane;
      end
   end

   always_comb begin
      commit_lane = '0;
      commit_addr = wr1_addr;
      if (active && pipe_mode && wr2_valid) begin
         commit_lane = wr2_lane;
         commit_addr = wr2_addr;
      end else if (active && !pipe_mode && wr1_valid) begin
         commit_lane = wr1_lane;
      end
   end

   // Storage
   logic [DATA_W-1:0] array_rd_data;

   sram_array #(
      .ADDR_W(ADDR_W),
      .BYTE_LANES(BYTE_LANES),
      .BYTE_W(BYTE_W)
   ) u_array (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .rd_en_i(do_read),
      .rd_addr_i(access_addr),
      .wr_lane_i(commit_lane),
      .wr_addr_i(commit_addr),
      .wr_data_i(dq_i),
      .rd_data_o(array_rd_data)
   );

   // Read pipeline: stage one drives in flow-through, stage two in pipeline
   logic rd1_valid;
   logic rd2_valid;
   logic [DATA_W-1:0] out_reg;
   logic drive;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         rd1_valid <= 1'h0;
         rd2_valid <= 1'h0;
         out_reg <= '0;
      end else if (active) begin
         rd1_valid <= do_read;
         rd2_valid <= rd1_valid;
         out_reg <= array_rd_data;
      end
   end

   // Stall keeps the driving stage as it was, so a read stays on the bus unless the stall is a sleep request
   assign drive = pipe_mode ? rd2_valid : rd1_valid;
   assign dq_o = pipe_mode ? out_reg : array_rd_data;
   assign dq_oe_o = {DATA_W{drive && !output_enable_n_i && !sleep_req}};

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   property p_ft_read;
      (do_read && !pipe_mode) |=> rd1_valid && drive;
   endproperty
   a_ft_read: assert property (p_ft_read) else $error("flow read not driven next cycle");

   property p_pipe_read;
      (do_read && pipe_mode) ##1 active |=> drive;
   endproperty
   a_pipe_read: assert property (p_pipe_read) else $error("pipeline read latency wrong");

   property p_ft_write;
      (do_write && !pipe_mode) ##1 active |-> commit_lane == $past(~byte_lane_write_n_i);
   endproperty
   a_ft_write: assert property (p_ft_write) else $error("flow write not at 2nd edge");

   property p_pipe_write;
      (do_write && pipe_mode) ##1 active ##1 active |-> commit_lane != '0;
   endproperty
   a_pipe_write: assert property (p_pipe_write) else $error("pipeline write not at 3rd edge");

   property p_write_float;
      do_write |=> !rd1_valid;
   endproperty
   a_write_float: assert property (p_write_float) else $error("drive after write");

   property p_nop_write;
      (active && next_state == OP_WRITE && !any_lane) |=> !wr1_valid;
   endproperty
   a_nop_write: assert property (p_nop_write) else $error("abort wrote data");

   property p_deselect;
      (active && load_cmd && deselect_cmd) |=> state == OP_DESELECT && !rd1_valid;
   endproperty
   a_deselect: assert property (p_deselect) else $error("deselect ignored");

   property p_desel_cont;
      (state == OP_DESELECT && active && advance_load_i) |=> state == OP_DESELECT;
   endproperty
   a_desel_cont: assert property (p_desel_cont) else $error("left deselect on continue");

   property p_stall;
      !active |=> $stable(state) && $stable(cur_low) && $stable(drive);
   endproperty
   a_stall: assert property (p_stall) else $error("state moved on ignored edge");

   property p_oe_off;
      (output_enable_n_i || sleep_req) |-> dq_oe_o == '0;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");

   property p_linear_step;
      (burst_advance && !burst_order_sel_n_i) |=> cur_low == 2'($past(cur_low) + 2'h1);
   endproperty
   a_linear_step: assert property (p_linear_step) else $error("linear step wrong");

   property p_wrap;
      burst_load ##1 (burst_advance [*4]) |=> burst_count == `BURST_CNT_START;
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst did not wrap");

   property p_ilv_step;
      (burst_advance && burst_order_sel_n_i) |=>
         (cur_low ^ $past(cur_low)) == ($past(burst_count[0]) ? 2'h3 : 2'h1);
   endproperty
   a_ilv_step: assert property (p_ilv_step) else $error("bad interleave step");

   property p_write_stall;
      (state == OP_WRITE && !active && !pipe_mode) |-> dq_oe_o == '0;
   endproperty
   a_write_stall: assert property (p_write_stall) else $error("write stall drove");

   property p_lane_source;
      (active && !load_cmd && state == OP_WRITE) |=> wr1_lane == $past(~byte_lane_write_n_i);
   endproperty
   a_lane_source: assert property (p_lane_source) else $error("lanes not current");

   c_read_burst: cover property (do_read ##1 burst_advance [*3]);
   c_read_to_write: cover property (do_read ##1 do_write);
   c_stall_read: cover property (rd1_valid && !active && drive);
   c_write_stall: cover property (state == OP_WRITE && !active);

endmodule : sync_sram_burst_control

//--- dv/sram_ctrl_model.sv
// Memory controller data side: presents late write data on the data bus
module sram_ctrl_model (
   input wire logic clk_i,
   input wire logic ce_n_i,
   input wire logic pipe_i,
   input wire logic wv_i,
   input wire logic [35:0] wd_i,
   output logic [35:0] dq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [35:0] stage = 36'h0;
   logic sv = 1'b0;
   initial dq_o = 36'h0;
   // Outside a data phase the bus inverts on each enabled edge, so stale data returns every other edge; it holds while clock enable is high
   always @(posedge clk_i) begin
      if (!ce_n_i) begin
         stage <= wd_i;
         sv <= wv_i;
         if (pipe_i ? sv : wv_i) begin
            dq_o <= pipe_i ? stage : wd_i;
         end else begin
            dq_o <= ~dq_o;
         end
      end
   end
endmodule : sram_ctrl_model

//--- dv/sync_sram_burst_control_tb_top.sv
// Testbench for the burst static RAM command, burst and data timing
module sync_sram_burst_control_tb_top
   import sram_burst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce_n = 1'b0, advance_load = 1'b0, wn = 1'b1, cs1_n = 1'b1, cs2 = 1'b0, cs3_n = 1'b1;
   logic oe_n = 1'b0, sleep = 1'b0, bo_n = 1'b0, ft_n = 1'b0, wv = 1'b0;
   logic [3:0] lanes = 4'hF;
   logic [17:0] addr = 18'h0;
   logic [35:0] wd = 36'h0;
   logic [35:0] dq_i, dq_o, dq_oe_o;
   logic [35:0] exp_mem [int];
   int err_total = 0;
   int compares = 0;
   always #20 clk_i = ~clk_i;

   sync_sram_burst_control sync_sram_burst_control_inst (
      .clk_i(clk_i), .reset_i(reset_i), .clock_enable_n_i(ce_n), .advance_load_i(advance_load),
      .write_n_i(wn), .byte_lane_write_n_i(lanes), .chip_select_1_n_i(cs1_n),
      .chip_select_2_i(cs2), .chip_select_3_n_i(cs3_n), .output_enable_n_i(oe_n),
      .sleep_request_i(sleep), .burst_order_sel_n_i(bo_n), .flow_through_sel_n_i(ft_n),
      .addr_i(addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

   sram_ctrl_model sram_ctrl_model_inst (.clk_i(clk_i), .ce_n_i(ce_n), .pipe_i(ft_n),
      .wv_i(wv), .wd_i(wd), .dq_o(dq_i));

   task automatic chk(input logic [35:0] seen, input logic [35:0] want);
      compares++;
      if (seen !== want) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic setup(input logic bo, input logic ft);
      @(posedge clk_i);
      {reset_i, bo_n, ft_n, sleep, oe_n} <= {1'b1, bo, ft, 2'b00};
      repeat (4) @(posedge clk_i);
      chk(dq_oe_o, 36'h0);
      reset_i <= 1'b0;
   endtask : setup

   // Command driven after one rising edge, taken at the next; sel 0 selects
   task automatic op(input logic a, input logic w, input logic c, input logic [1:0] sel,
      input logic [3:0] ln, input logic [17:0] ad, input logic [35:0] d);
      @(posedge clk_i);
      {advance_load, wn, ce_n, lanes, addr, wd} <= {a, w, c, ln, ad, d};
      {cs1_n, cs2, cs3_n} <= {sel == 2'h1, sel != 2'h2, sel == 2'h3};
      wv <= !w && sel == 2'h0;
      @(negedge clk_i);
   endtask : op

   function automatic logic [17:0] baddr(input logic [17:0] b, input int i);
      baddr = {b[17:2], bo_n ? b[1:0] ^ 2'(i) : b[1:0] + 2'(i)};
   endfunction : baddr

   // Burst of cnt accesses, then lat deselects so read data drain out
   task automatic burst(input logic w, input logic [17:0] b, input int cnt, input int lat);
      logic [17:0] a;
      for (int i = 0; i < cnt + lat; i++) begin
         a = baddr(b, i);
         if (i < cnt) begin
            op(i != 0, w, 1'b0, 2'h0, 4'h0, a, {b, 18'(i)});
            if (!w) exp_mem[a] = {b, 18'(i)};
         end else begin
            op(1'b0, 1'b1, 1'b0, 2'h1, 4'h0, 18'h0, 36'h0);
         end
         if (!w) chk(dq_oe_o, 36'h0);
         if (w && i >= lat) begin
            chk(dq_oe_o, '1);
            chk(dq_o, exp_mem[baddr(b, i - lat)]);
         end
      end
   endtask : burst

   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      end_of_test();
   end

   initial begin
      setup(1'b0, 1'b0);
      burst(1'b0, 18'h101, 5, 1);
      burst(1'b1, 18'h101, 5, 1);
      burst(1'b0, 18'h8, 2, 1);
      op(1'b0, 1'b0, 1'b0, 2'h0, 4'hA, 18'h8, 36'h1_2345_6789);
      exp_mem[8] = (exp_mem[8] & ~36'h0_07FC_01FF) | (36'h1_2345_6789 & 36'h0_07FC_01FF);
      op(1'b1, 1'b0, 1'b0, 2'h0, 4'hF, 18'h0, 36'hF_FFFF_FFFF);
      op(1'b0, 1'b0, 1'b0, 2'h0, 4'hF, 18'h8, 36'h0);
      burst(1'b1, 18'h8, 2, 1);
      op(1'b0, 1'b0, 1'b0, 2'h0, 4'h0, 18'h10, 36'h9_8765_4321);
      exp_mem[18'h10] = 36'h9_8765_4321;
      op(1'b0, 1'b1, 1'b1, 2'h0, 4'hF, 18'h0, 36'h0);
      chk(dq_oe_o, 36'h0);
      op(1'b0, 1'b1, 1'b0, 2'h1, 4'hF, 18'h0, 36'h0);
      chk(dq_oe_o, 36'h0);
      burst(1'b1, 18'h10, 1, 1);
      for (int k = 1; k < 4; k++) begin
         op(1'b0, 1'b1, 1'b0, 2'h0, 4'hF, 18'h8, 36'h0);
         op(1'b0, 1'b0, 1'b0, 2'(k), 4'h0, 18'h0, 36'h0);
         chk(dq_oe_o, '1);
         op(1'b1, 1'b1, 1'b0, 2'h0, 4'hF, 18'h0, 36'h0);
         chk(dq_oe_o, 36'h0);
         op(1'b0, 1'b1, 1'b0, 2'h1, 4'hF, 18'h0, 36'h0);
         chk(dq_oe_o, 36'h0);
      end
      op(1'b0, 1'b1, 1'b0, 2'h0, 4'hF, 18'h101, 36'h0);
      op(1'b0, 1'b1, 1'b1, 2'h0, 4'hF, 18'h0, 36'h0);
      op(1'b0, 1'b1, 1'b1, 2'h0, 4'hF, 18'h0, 36'h0);
      chk(dq_oe_o, '1);
      chk(dq_o, exp_mem[18'h101]);
      @(posedge clk_i) oe_n <= 1'b1;
      @(negedge clk_i) chk(dq_oe_o, 36'h0);
      @(posedge clk_i) oe_n <= 1'b0;
      op(1'b1, 1'b1, 1'b0, 2'h1, 4'hF, 18'h0, 36'h0);
      op(1'b0, 1'b1, 1'b0, 2'h1, 4'hF, 18'h0, 36'h0);
      chk(dq_o, exp_mem[18'h102]);
      op(1'b0, 1'b1, 1'b0, 2'h0, 4'hF, 18'h8, 36'h0);
      @(posedge clk_i) sleep <= 1'b1;
      repeat (3) op(1'b1, 1'b1, 1'b0, 2'h0, 4'hF, 18'h0, 36'h0);
      chk(dq_oe_o, 36'h0);
      setup(1'b1, 1'b0);
      burst(1'b0, 18'h200, 4, 1);
      burst(1'b1, 18'h202, 5, 1);
      setup(1'b0, 1'b1);
      burst(1'b0, 18'h301, 5, 2);
      burst(1'b1, 18'h302, 5, 2);
      end_of_test();
   end
endmodule : sync_sram_burst_control_tb_top
